// File: bbw_map.svh
`ifndef BBW_MAP_SVH
`define BBW_MAP_SVH

// Data layout
`define BBW_DW 64
`define BBW_AW 16
`define BBW_SW 8
`define BBW_TW 4
// Byte address bits below the word index
`define BBW_ALSB 3
// Default slave wait states before acknowledge
`define BBW_WAIT_DEF 0
// Default pipeline queue depth
`define BBW_QDEPTH 4
`define BBW_QPTRW 2
`define BBW_QCNTW 3
`endif

// File: bbw_pkg.sv
package bbw_pkg;
`include "bbw_map.svh"
    // Request seen at slave inputs
    typedef struct packed {
        logic [`BBW_AW-1:0] adr;
        logic [`BBW_TW-1:0] tga;
        logic [`BBW_DW-1:0] dat;
        logic [`BBW_TW-1:0] tgd;
        logic [`BBW_SW-1:0] sel;
        logic we;
    } bbw_req_t;
    // Answer data back to the master
    typedef struct packed {
        logic [`BBW_DW-1:0] dat;
        logic [`BBW_TW-1:0] tgd;
    } bbw_rsp_t;
    // Slave phase states
    typedef enum logic [1:0] {
        BBW_IDLE = 2'b00,
        BBW_WAIT = 2'b01,
        BBW_ACK = 2'b10
    } bbw_state_t;
endpackage

// File: bbw_mem.sv
`timescale 1ns/10ps
`include "bbw_map.svh"
// Word memory with byte lanes and registered read data
module bbw_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    // Clock
    input wire logic i_clock,
    // Access
    input wire logic i_en,
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [`BBW_SW-1:0] i_be,
    input wire logic [`BBW_DW-1:0] i_wdata,
    output logic [`BBW_DW-1:0] o_rdata
);
    // Storage array, no reset on contents
    logic [`BBW_DW-1:0] mem_reg [DEPTH];
    // One lane per select bit; lanes are fixed so both orders live in software
    genvar g;
    generate
        for (g = 0; g < `BBW_SW; g++) begin : g_lane
            always_ff @(posedge i_clock) begin
                if (i_en && i_we && i_be[g]) begin
                    mem_reg[i_addr][g*8 +: 8] <= i_wdata[g*8 +: 8];
                end
            end
        end
    endgenerate
    // Registered read port, old data on a write cycle
    always_ff @(posedge i_clock) begin
        if (i_en && !i_we) begin
            o_rdata <= mem_reg[i_addr];
        end
    end
endmodule

// File: bbw_slave.sv
`timescale 1ns/10ps
`include "bbw_map.svh"
// Bus slave: standard, pipelined and read-modify-write phases on a memory
module bbw_slave
    import bbw_pkg::*;
#(
    parameter int WAIT = `BBW_WAIT_DEF,
    parameter int QDEPTH = `BBW_QDEPTH,
    parameter int MAW = 8
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_arst_n,
    // Mode and decode
    input wire logic i_pipelined,
    input wire logic i_select,
    // Master request
    input wire logic i_cyc,
    input wire logic i_stb,
    input wire logic [`BBW_TW-1:0] i_tgc,
    input wire bbw_pkg::bbw_req_t i_req,
    // Answer
    output logic o_ack,
    output logic o_stall,
    output bbw_pkg::bbw_rsp_t o_rsp,
    // Last captured write, for the user side
    output bbw_pkg::bbw_req_t o_wr_last,
    output logic o_wr_pulse
);
    import bbw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Common terms
    ////////////////////////////////////////////////////////////////////////
    // Only our decoded strobe counts
    logic hit;
    assign hit = i_cyc && i_stb && i_select;
    // Memory word address
    logic [MAW-1:0] waddr;
    assign waddr = i_req.adr[`BBW_ALSB +: MAW];
    // Memory port wires
    logic mem_en;
    logic mem_we;
    logic [MAW-1:0] mem_addr;
    logic [`BBW_SW-1:0] mem_be;
    logic [`BBW_DW-1:0] mem_wdata;
    logic [`BBW_DW-1:0] mem_rdata;
    // Wait counter width fixed, waits limited to 256
    logic [7:0] wcnt_reg;
    bbw_state_t state_reg;
    logic std_ack_reg;
    logic std_take;
    // Standard read strobe, read data already issued, tag of that read
    logic pre_en;
    logic rd_valid_reg;
    logic [`BBW_TW-1:0] rtag_reg;

    ////////////////////////////////////////////////////////////////////////
    // Standard mode: one acknowledge per strobed phase
    ////////////////////////////////////////////////////////////////////////
    // Acknowledge after WAIT clocks, dropped the clock strobe falls
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= BBW_IDLE;
            wcnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                BBW_IDLE: begin
                    if (hit && !i_pipelined) begin
                        wcnt_reg <= 8'h00;
                        state_reg <= (WAIT == 0) ? BBW_ACK : BBW_WAIT;
                    end
                end
                BBW_WAIT: begin
                    // Master withdrew strobe: abandon phase
                    if (!hit) begin
                        state_reg <= BBW_IDLE;
                    end else if (wcnt_reg == 8'(WAIT - 1)) begin
                        state_reg <= BBW_ACK;
                    end else begin
                        wcnt_reg <= wcnt_reg + 8'h01;
                    end
                end
                BBW_ACK: begin
                    // Zero-wait slaves take the next phase at once
                    if (hit && WAIT == 0) begin
                        state_reg <= BBW_ACK;
                    end else begin
                        state_reg <= BBW_IDLE;
                    end
                end
                default: state_reg <= BBW_IDLE;
            endcase
        end
    end
    // Acknowledge only while strobe still up, so one per phase
    assign std_ack_reg = (state_reg == BBW_ACK);
    // Reads wait until the registered memory holds this phase's word
    assign std_take = std_ack_reg && hit && !i_pipelined
                      && (i_req.we || rd_valid_reg);

    ////////////////////////////////////////////////////////////////////////
    // Pipelined mode: in-flight counter acts as the request queue
    ////////////////////////////////////////////////////////////////////////
    // Queue depth models internal buffering; stall when full
    logic [`BBW_QCNTW-1:0] qcnt_reg;
    logic pipe_take;
    logic pipe_ack_reg;
    assign o_stall = i_pipelined && i_select
                     && (qcnt_reg == `BBW_QCNTW'(QDEPTH));
    assign pipe_take = hit && i_pipelined && !o_stall;
    // Requests still unanswered after this edge
    logic [`BBW_QCNTW-1:0] qcnt_next;
    assign qcnt_next = qcnt_reg + `BBW_QCNTW'(pipe_take) - `BBW_QCNTW'(pipe_ack_reg);
    // One acknowledge a clock drains the queue, never one too many
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            qcnt_reg <= '0;
            pipe_ack_reg <= 1'b0;
        end else begin
            pipe_ack_reg <= i_cyc && (qcnt_next != '0);
            if (!i_cyc) begin
                qcnt_reg <= '0;
            end else begin
                qcnt_reg <= qcnt_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory access and write capture
    ////////////////////////////////////////////////////////////////////////
    // Reads run on every standard read strobe so data stand with the acknowledge
    assign pre_en = hit && !i_req.we && !i_pipelined;
    assign mem_en = std_take || pipe_take || pre_en;
    // Writes only on a taken phase, never during wait states
    assign mem_we = i_req.we && (std_take || pipe_take);
    assign mem_addr = waddr;
    assign mem_be = i_req.sel;
    assign mem_wdata = i_req.dat;
    bbw_mem #(.DEPTH(1 << MAW), .AW(MAW)) u_mem (
        .i_clock(i_clock),
        .i_en(mem_en),
        .i_we(mem_we),
        .i_addr(mem_addr),
        .i_be(mem_be),
        .i_wdata(mem_wdata),
        .o_rdata(mem_rdata)
    );
    // Read issued for a phase not answered now: data good next clock
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rd_valid_reg <= 1'b0;
            rtag_reg <= '0;
        end else begin
            rd_valid_reg <= pre_en && !std_take;
            if (mem_en && !mem_we) begin
                rtag_reg <= i_req.tga;
            end
        end
    end
    // Write capture at the acknowledge edge in standard mode, a clock before the acknowledge when pipelined
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wr_last <= '0;
            o_wr_pulse <= 1'b0;
        end else begin
            o_wr_pulse <= 1'b0;
            if (mem_we) begin
                o_wr_last <= i_req;
                o_wr_pulse <= 1'b1;
            end
        end
    end
    // Read data straight from the registered memory port
    assign o_rsp = {mem_rdata, rtag_reg};

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge output
    ////////////////////////////////////////////////////////////////////////
    // RMW is two ordinary phases inside one cycle; nothing else may cut in
    assign o_ack = i_pipelined ? pipe_ack_reg : std_take;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////
    property p_ack_needs_strobe;
        @(posedge i_clock) disable iff (!i_arst_n)
        (o_ack && !i_pipelined) |-> (i_stb && i_cyc && i_select);
    endproperty
    a_ack_needs_strobe: assert property (p_ack_needs_strobe)
        else $error("ack without strobe");
    property p_ack_drops;
        @(posedge i_clock) disable iff (!i_arst_n)
        (!i_pipelined && !i_stb) |-> !o_ack;
    endproperty
    a_ack_drops: assert property (p_ack_drops)
        else $error("ack held after strobe fell");
    property p_zero_wait;
        @(posedge i_clock) disable iff (!i_arst_n)
        (WAIT == 0 && !i_pipelined && hit && state_reg == BBW_IDLE) ##1 hit |-> o_ack;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("no ack one clock after strobe");
    property p_write_capture;
        @(posedge i_clock) disable iff (!i_arst_n)
        (std_take && i_req.we) |=> (o_wr_pulse && o_wr_last.dat == $past(i_req.dat));
    endproperty
    a_write_capture: assert property (p_write_capture)
        else $error("write data not captured");
    property p_stall_full;
        @(posedge i_clock) disable iff (!i_arst_n)
        o_stall |-> (qcnt_reg == `BBW_QCNTW'(QDEPTH) && pipe_ack_reg);
    endproperty
    a_stall_full: assert property (p_stall_full)
        else $error("stall while queue not full");
    property p_stall_no_take;
        @(posedge i_clock) disable iff (!i_arst_n)
        (o_stall && hit) |=> (qcnt_reg == $past(qcnt_reg) - `BBW_QCNTW'(1));
    endproperty
    a_stall_no_take: assert property (p_stall_no_take)
        else $error("stalled request accepted");
    property p_pipe_ack;
        @(posedge i_clock) disable iff (!i_arst_n)
        (i_pipelined && pipe_take) |=> o_ack;
    endproperty
    a_pipe_ack: assert property (p_pipe_ack)
        else $error("outstanding request not acknowledged");
    property p_wait_count;
        @(posedge i_clock) disable iff (!i_arst_n)
        (WAIT == 2 && !i_pipelined && hit && state_reg == BBW_IDLE) ##1 hit ##1 hit
        |-> !o_ack;
    endproperty
    a_wait_count: assert property (p_wait_count)
        else $error("ack came before wait states");
endmodule

// File: bbw_master.sv
`timescale 1ns/10ps
// Bus master stand-in: drives phases, repeats stalled requests, counts acknowledges
module bbw_master
    import bbw_pkg::*;
(
    // Clock
    input wire logic i_clock,
    // Answer from the slave
    input wire logic i_ack,
    input wire logic i_stall,
    // Request to the slave
    output logic o_cyc,
    output logic o_stb,
    output bbw_pkg::bbw_req_t o_req
);
    int n_ack = 0; // Acknowledges seen while the cycle is open
    int n_acc = 0; // Requests taken by the slave
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_req = '0;
    end
    ////////////////////////////////////////////////////////////////
    // Outstanding count, so pipelined close knows when to drop cycle
    always @(posedge i_clock) begin
        if (o_cyc && i_ack === 1'b1) begin
            n_ack <= n_ack + 1;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Standard phase: request held until acknowledge sampled or lim clocks have passed
    task automatic std_phase(input bbw_req_t r, input int lim, output logic ok);
        int t;
        o_cyc = 1'b1;
        o_stb = 1'b1;
        o_req = r;
        t = 0;
        do begin
            @(posedge i_clock);
            t++;
        end while (i_ack !== 1'b1 && t < lim);
        ok = (i_ack === 1'b1);
        if (ok) n_acc++;
        #1;
    endtask
    // Pipelined request: repeated unchanged while stalled
    task automatic pipe(input bbw_req_t r);
        int t;
        o_cyc = 1'b1;
        o_stb = 1'b1;
        o_req = r;
        t = 0;
        do begin
            @(posedge i_clock);
            t++;
        end while (i_stall !== 1'b0 && t < 300);
        n_acc++;
        #1;
    endtask
    // Master wait state: strobe low, cycle kept, data no longer valid
    task automatic gap(input int n);
        o_stb = 1'b0;
        o_req.dat = ~o_req.dat;
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    // End of cycle: cycle held until every taken request is answered
    task automatic close();
        o_stb = 1'b0;
        o_req.dat = ~o_req.dat;
        for (int t = 0; t < 300 && n_ack < n_acc; t++) begin
            @(posedge i_clock);
            #1;
        end
        o_cyc = 1'b0;
        // Let the slave see the idle bus before any new cycle
        @(posedge i_clock);
        #1;
    endtask
endmodule

// File: tb_bus_block_write_rmw_ordering.sv
`timescale 1ns/10ps
`include "bbw_map.svh"
// Random and corner traffic; every captured write is matched against a queue
module tb_bus_block_write_rmw_ordering;
    import bbw_pkg::*;
    logic i_clock = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_pipelined = 1'b0;
    logic i_select = 1'b1;
    logic [3:0] i_tgc = '0;
    logic cyc, stb, o_ack, o_stall, o_wr_pulse, got;
    bbw_req_t req, o_wr_last, r;
    bbw_rsp_t o_rsp;
    bbw_req_t exp_q[$]; // Writes in expected capture order
    int n_errors = 0;
    int n_checks = 0;
    int n_stall = 0; // Clocks with the slave queue full
    always #20 i_clock = ~i_clock;
    // Single-entry queue so the burst really meets stall
    bbw_slave #(.QDEPTH(1)) bbw_slave_inst (.i_clock(i_clock), .i_arst_n(i_arst_n),
        .i_pipelined(i_pipelined), .i_select(i_select), .i_cyc(cyc), .i_stb(stb),
        .i_tgc(i_tgc), .i_req(req), .o_ack(o_ack), .o_stall(o_stall), .o_rsp(o_rsp),
        .o_wr_last(o_wr_last), .o_wr_pulse(o_wr_pulse));
    bbw_master bbw_master_inst (.i_clock(i_clock), .i_ack(o_ack), .i_stall(o_stall),
        .o_cyc(cyc), .o_stb(stb), .o_req(req));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Random request; at least one byte lane selected
    function automatic bbw_req_t mk(input logic we);
        bbw_req_t q;
        q.adr = 16'($urandom);
        q.tga = 4'($urandom);
        q.dat = {$urandom, $urandom};
        q.tgd = 4'($urandom);
        q.sel = 8'($urandom) | 8'h01;
        q.we = we;
        return q;
    endfunction
    // One phase; writes queued before they are offered
    task automatic wr(input bbw_req_t q, input logic piped);
        if (q.we) exp_q.push_back(q);
        if (piped) bbw_master_inst.pipe(q);
        else bbw_master_inst.std_phase(q, 300, got);
    endtask
    task automatic acks();
        check("ack count", bbw_master_inst.n_ack, bbw_master_inst.n_acc);
    endtask
    ////////////////////////////////////////////////////////////////
    // Every write pulse must carry the oldest queued write
    always @(posedge i_clock) begin
        if (o_wr_pulse === 1'b1) begin
            if (exp_q.size() == 0) check("spurious write", 1, 0);
            else check("captured write", 128'(o_wr_last), 128'(exp_q.pop_front()));
        end
    end
    always @(posedge i_clock) begin
        if (o_stall === 1'b1) n_stall++;
    end
    // Watchdog, far beyond the hundred or so cycles of the run
    initial begin
        repeat (5000) @(posedge i_clock);
        n_errors++;
        end_sim();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(29));
        i_tgc = 4'($urandom);
        repeat (10) @(posedge i_clock);
        #1;
        i_arst_n = 1'b1;
        @(posedge i_clock);
        #1;
        // Standard block write, master wait after the second phase and at random
        for (int i = 0; i < 12; i++) begin
            wr(mk(1'b1), 1'b0);
            if (i == 1 || $urandom_range(2) == 0) bbw_master_inst.gap(1 + $urandom_range(2));
        end
        // Quadword whole on the port, top byte on lane 7
        r = mk(1'b1);
        r.dat = 64'h0123456789ABCDEF;
        r.sel = 8'hFF;
        wr(r, 1'b0);
        // Read the quadword back in the same cycle
        r.we = 1'b0;
        wr(r, 1'b0);
        check("read data", o_rsp.dat, 64'h0123456789ABCDEF);
        check("read tag", o_rsp.tgd, r.tga);
        bbw_master_inst.close();
        acks();
        // Not selected: no acknowledge at all
        i_select = 1'b0;
        bbw_master_inst.std_phase(mk(1'b1), 6, got);
        check("unselected ack", got, 1'b0);
        bbw_master_inst.close();
        i_select = 1'b1;
        // Pipelined burst with random reads and writes
        i_pipelined = 1'b1;
        for (int i = 0; i < 10; i++) wr(mk(1'($urandom_range(1))), 1'b1);
        bbw_master_inst.close();
        acks();
        check("stall seen", n_stall > 0, 1'b1);
        // Read then write under one cycle, master waits between halves
        i_pipelined = 1'b0;
        wr(mk(1'b0), 1'b0);
        bbw_master_inst.gap(3);
        wr(mk(1'b1), 1'b0);
        bbw_master_inst.close();
        acks();
        repeat (3) @(posedge i_clock);
        check("pending writes", exp_q.size(), 0);
        end_sim();
    end
endmodule
